//--- dv/opm_pin_mux_assertions.sv
`timescale 1ns/10ps
module opm_pin_mux_assertions (
    // bus
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [11:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    // pins and crystal clock source
    input wire logic i_crystal_reference_clock,
    input wire logic o_indicator_pin_a,
    input wire logic o_indicator_pin_b,
    input wire logic o_clock_output_pin,
    input wire logic [3:0] o_rx_pin_termination_code
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    wire wr_term = i_wr && i_addr == opm_pkg::ADDR_TERM;
    wire wr_ind = i_wr && i_addr == opm_pkg::ADDR_IND;
    wire wr_clk = i_wr && i_addr == opm_pkg::ADDR_CLK;
    property p_rd_idle;
        !i_rd |=> o_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rsv;
        i_rd && i_addr == opm_pkg::ADDR_IND |=> (o_rdata & 16'h8888) == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_term_wr;
        wr_term |=> o_rx_pin_termination_code == $past(i_wdata[4:1]);
    endproperty
    a_term_wr: assert property (p_term_wr) else $error("termination code not written");
    property p_term_hold;
        !wr_term |=> $stable(o_rx_pin_termination_code);
    endproperty
    a_term_hold: assert property (p_term_hold) else $error("termination code moved");
    property p_pa;
        wr_ind && i_wdata[2:1] == 2'h3 |=> o_indicator_pin_a == $past(i_wdata[0]);
    endproperty
    a_pa: assert property (p_pa) else $error("pin a constant wrong");
    property p_pb;
        wr_ind && i_wdata[10:9] == 2'h3 |=> o_indicator_pin_b == $past(i_wdata[8]);
    endproperty
    a_pb: assert property (p_pb) else $error("pin b constant wrong");
    property p_cp;
        wr_clk && i_wdata[2:1] == 2'h3 |=> o_clock_output_pin == $past(i_wdata[0]);
    endproperty
    a_cp: assert property (p_cp) else $error("clock pin constant wrong");
    property p_rst_ck;
        $fell(i_sys_rst) |-> o_clock_output_pin == i_crystal_reference_clock;
    endproperty
    a_rst_ck: assert property (p_rst_ck) else $error("no crystal clock after reset");
endmodule

//--- dv/opm_pin_mux_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module opm_pin_mux_bench;
    logic clk, rst, wr, rd, pa, pb, cp;
    logic [11:0] addr;
    logic [15:0] wdata, rdata, ind, ckr, d;
    logic [8:0] s;
    logic [3:0] term;
    opm_pkg::opm_strap_s strap;
    int seed = 30;
    int error_cnt = 0;
    int n_tests = 0;
    opm_pin_mux i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_indicator_pin_a(s[0]),
        .i_indicator_pin_b(s[1]), .i_indicator_signal_c(s[2]), .i_crystal_reference_clock(s[3]),
        .i_transmit_line_clock(s[4]), .i_wake_packet_indication(s[5]), .i_undervoltage(s[6]),
        .i_ts_tx_event(s[7]), .i_ts_rx_event(s[8]), .i_strap_mode(strap),
        .o_indicator_pin_a(pa), .o_indicator_pin_b(pb), .o_clock_output_pin(cp),
        .o_rx_pin_termination_code(term));
    // sources indexed by function code; only code 1 of the clock select picks the line clock
    function automatic logic pin_exp(input logic [2:0] fn, input logic [3:0] ck, input logic own);
        logic [7:0] t;
        t = {2'b10, s[8:5], (ck == 4'h1) ? s[4] : s[3], own};
        pin_exp = t[fn];
    endfunction
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e)
    endtask
    task automatic pins;
        @(posedge clk);
        s <= 9'($random(seed));
        @(negedge clk);
        `CHK(pa, pin_exp(ind[2:0], {1'b0, ind[6:4]}, s[0]))
        `CHK(pb, pin_exp(ind[10:8], {1'b0, ind[14:12]}, s[1]))
        `CHK(cp, pin_exp(ckr[2:0], ckr[7:4], s[2]))
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #1000000;
        error_cnt++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 12'h000;
        wdata = 16'h0000;
        s = 9'h000;
        strap = 16'($random(seed));
        ind = 16'h0000;
        ckr = 16'h0001;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        pins();
        `CHK(term, 4'h8)
        rd_chk(opm_pkg::ADDR_TERM, 16'h0410);
        rd_chk(opm_pkg::ADDR_IND, 16'h0000);
        rd_chk(opm_pkg::ADDR_CLK, 16'h0001);
        wr_reg(opm_pkg::ADDR_STRAP, ~strap);
        rd_chk(opm_pkg::ADDR_STRAP, strap);
        rd_chk(12'h465, 16'h0000);
        $display("reset and strap test done");
        for (int i = 0; i < 200; i++) begin
            d = 16'($random(seed));
            ind = 16'($random(seed));
            ckr = 16'($random(seed));
            if (i % 4 == 0)
                ckr[7:4] = 4'h1;
            wr_reg(opm_pkg::ADDR_TERM, d);
            wr_reg(opm_pkg::ADDR_IND, ind);
            wr_reg(opm_pkg::ADDR_CLK, ckr);
            @(negedge clk);
            `CHK(term, d[4:1])
            repeat (3) pins();
            rd_chk(opm_pkg::ADDR_TERM, d);
            rd_chk(opm_pkg::ADDR_IND, ind & 16'h7777);
            rd_chk(opm_pkg::ADDR_CLK, ckr & 16'h00F7);
        end
        $display("random mux test done");
        conclude();
    end
endmodule
bind opm_pin_mux opm_pin_mux_assertions i_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_crystal_reference_clock(i_crystal_reference_clock), .o_indicator_pin_a(o_indicator_pin_a),
    .o_indicator_pin_b(o_indicator_pin_b), .o_clock_output_pin(o_clock_output_pin),
    .o_rx_pin_termination_code(o_rx_pin_termination_code));

//--- rtl/opm_pin_mux.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module opm_pin_mux (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // register port
    input wire logic [11:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // signal sources
    input wire logic i_indicator_pin_a,
    input wire logic i_indicator_pin_b,
    input wire logic i_indicator_signal_c,
    input wire logic i_crystal_reference_clock,
    input wire logic i_transmit_line_clock,
    input wire logic i_wake_packet_indication,
    input wire logic i_undervoltage,
    input wire logic i_ts_tx_event,
    input wire logic i_ts_rx_event,
    // strap modes from the strap detector, stable around reset release
    input wire opm_pkg::opm_strap_s i_strap_mode,
    // pins
    output logic o_indicator_pin_a,
    output logic o_indicator_pin_b,
    output logic o_clock_output_pin,
    output logic [3:0] o_rx_pin_termination_code
);

    // ****************************************
    // registers
    // ****************************************
    logic [3:0] term_q;
    logic [10:0] term_rsv_q;
    logic term_b0_q;
    logic [2:0] pa_fn_q;
    logic [2:0] pa_ck_q;
    logic [2:0] pb_fn_q;
    logic [2:0] pb_ck_q;
    logic [2:0] cp_fn_q;
    logic [3:0] cp_ck_q;
    opm_pkg::opm_strap_s strap_q;
    opm_pkg::opm_strap_s strap_s1_q;
    opm_pkg::opm_strap_s strap_s2_q;
    logic cap_pend_q;
    logic [15:0] rdata_q;

    wire logic wr_term;
    wire logic wr_ind;
    wire logic wr_clk;
    wire logic [15:0] rd_term;
    wire logic [15:0] rd_ind;
    wire logic [15:0] rd_clk;
    wire logic [15:0] rd_mux;
    opm_pkg::opm_src_s src;

    // ****************************************
    // decode
    // ****************************************
    assign wr_term = i_wr && (i_addr == opm_pkg::ADDR_TERM);
    assign wr_ind = i_wr && (i_addr == opm_pkg::ADDR_IND);
    assign wr_clk = i_wr && (i_addr == opm_pkg::ADDR_CLK);

    assign rd_term = {term_rsv_q, term_q, term_b0_q};
    assign rd_ind = {1'b0, pb_ck_q, 1'b0, pb_fn_q, 1'b0, pa_ck_q, 1'b0, pa_fn_q};
    assign rd_clk = {8'h00, cp_ck_q, 1'b0, cp_fn_q};
    assign rd_mux = (i_addr == opm_pkg::ADDR_TERM) ? rd_term :
                    (i_addr == opm_pkg::ADDR_IND) ? rd_ind :
                    (i_addr == opm_pkg::ADDR_CLK) ? rd_clk :
                    (i_addr == opm_pkg::ADDR_STRAP) ? strap_q :
                    16'h0000;

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            term_q <= opm_pkg::TERM_RST;
            term_rsv_q <= opm_pkg::TERM_RSV_RST;
            term_b0_q <= opm_pkg::TERM_B0_RST;
        end else if (wr_term) begin
            term_q <= i_wdata[opm_pkg::TERM_LSB +: 4];
            term_rsv_q <= i_wdata[opm_pkg::TERM_RSV_LSB +: 11];
            term_b0_q <= i_wdata[0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pa_fn_q <= opm_pkg::PA_FN_RST;
            pa_ck_q <= opm_pkg::PIN_CK_RST;
            pb_fn_q <= opm_pkg::PB_FN_RST;
            pb_ck_q <= opm_pkg::PIN_CK_RST;
        end else if (wr_ind) begin
            pa_fn_q <= i_wdata[opm_pkg::PA_FN_LSB +: 3];
            pa_ck_q <= i_wdata[opm_pkg::PA_CK_LSB +: 3];
            pb_fn_q <= i_wdata[opm_pkg::PB_FN_LSB +: 3];
            pb_ck_q <= i_wdata[opm_pkg::PB_CK_LSB +: 3];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cp_fn_q <= opm_pkg::CP_FN_RST;
            cp_ck_q <= opm_pkg::CP_CK_RST;
        end else if (wr_clk) begin
            cp_fn_q <= i_wdata[opm_pkg::CP_FN_LSB +: 3];
            cp_ck_q <= i_wdata[opm_pkg::CP_CK_LSB +: 4];
        end
    end

    // ****************************************
    // strap capture
    // ****************************************
    // two-stage sync, then one capture on the first cycle after reset release
    always_ff @(posedge i_sys_clk) begin
        strap_s1_q <= i_strap_mode;
        strap_s2_q <= strap_s1_q;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cap_pend_q <= 1'b1;
            strap_q <= '0;
        end else if (cap_pend_q) begin
            cap_pend_q <= 1'b0;
            strap_q <= strap_s2_q;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rdata_q <= 16'h0000;
        end else if (i_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign o_rdata = rdata_q;
    assign o_rx_pin_termination_code = term_q;

    // ****************************************
    // pin multiplexers
    // ****************************************
    assign src = '{xtal_clk: i_crystal_reference_clock, line_clk: i_transmit_line_clock,
                   wake: i_wake_packet_indication, undervolt: i_undervoltage,
                   ts_tx: i_ts_tx_event, ts_rx: i_ts_rx_event};

    opm_pin_sel u_pin_a (
        .i_func_sel(pa_fn_q),
        .i_clk_sel({1'b0, pa_ck_q}),
        .i_own(i_indicator_pin_a),
        .i_src(src),
        .o_pin(o_indicator_pin_a)
    );

    opm_pin_sel u_pin_b (
        .i_func_sel(pb_fn_q),
        .i_clk_sel({1'b0, pb_ck_q}),
        .i_own(i_indicator_pin_b),
        .i_src(src),
        .o_pin(o_indicator_pin_b)
    );

    opm_pin_sel u_clk_pin (
        .i_func_sel(cp_fn_q),
        .i_clk_sel(cp_ck_q),
        .i_own(i_indicator_signal_c),
        .i_src(src),
        .o_pin(o_clock_output_pin)
    );

endmodule

//--- rtl/opm_pin_sel.sv
`timescale 1ns/10ps
module opm_pin_sel (
    // control
    input wire logic [2:0] i_func_sel,
    input wire logic [3:0] i_clk_sel,
    // sources
    input wire logic i_own,
    input wire opm_pkg::opm_src_s i_src,
    // pin
    output logic o_pin
);
    wire logic clk_pick;
    wire logic [7:0] fn_vec;

    // only the line clock code picks it; every other code is the crystal
    assign clk_pick = (i_clk_sel == opm_pkg::CK_LINE) ? i_src.line_clk : i_src.xtal_clk;

    assign fn_vec = {1'b1, 1'b0, i_src.ts_rx, i_src.ts_tx, i_src.undervolt,
                     i_src.wake, clk_pick, i_own};
    assign o_pin = fn_vec[i_func_sel];
endmodule

//--- rtl/opm_pkg.sv
package opm_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] ADDR_TERM = 12'h461;
    localparam logic [11:0] ADDR_IND = 12'h462;
    localparam logic [11:0] ADDR_CLK = 12'h463;
    localparam logic [11:0] ADDR_STRAP = 12'h467;

    // ****************************************
    // field positions
    // ****************************************
    localparam int TERM_LSB = 1;
    localparam int TERM_RSV_LSB = 5;
    localparam int PA_FN_LSB = 0;
    localparam int PA_CK_LSB = 4;
    localparam int PB_FN_LSB = 8;
    localparam int PB_CK_LSB = 12;
    localparam int CP_FN_LSB = 0;
    localparam int CP_CK_LSB = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0] TERM_RST = 4'h8;
    localparam logic [10:0] TERM_RSV_RST = 11'h020;
    localparam logic TERM_B0_RST = 1'h0;
    localparam logic [2:0] PA_FN_RST = 3'h0;
    localparam logic [2:0] PB_FN_RST = 3'h0;
    localparam logic [2:0] CP_FN_RST = 3'h1;
    localparam logic [2:0] PIN_CK_RST = 3'h0;
    localparam logic [3:0] CP_CK_RST = 4'h0;

    // ****************************************
    // codes
    // ****************************************
    localparam logic [2:0] FN_OWN = 3'h0;
    localparam logic [2:0] FN_CLOCK = 3'h1;
    localparam logic [2:0] FN_WAKE = 3'h2;
    localparam logic [2:0] FN_UV = 3'h3;
    localparam logic [2:0] FN_TS_TX = 3'h4;
    localparam logic [2:0] FN_TS_RX = 3'h5;
    localparam logic [2:0] FN_LOW = 3'h6;
    localparam logic [2:0] FN_HIGH = 3'h7;
    localparam logic [3:0] CK_LINE = 4'h1;

    // sources shared by all three pins
    typedef struct packed {
        logic xtal_clk;
        logic line_clk;
        logic wake;
        logic undervolt;
        logic ts_tx;
        logic ts_rx;
    } opm_src_s;

    // one 2-bit mode per strap pin, msb field first
    typedef struct packed {
        logic [1:0] pin_b;
        logic [1:0] rx_valid;
        logic [1:0] rx_err;
        logic [1:0] pin_a;
        logic [1:0] rxd0;
        logic [1:0] rxd1;
        logic [1:0] rxd2;
        logic [1:0] rxd3;
    } opm_strap_s;

endpackage
